// ===== sim/mfr_ctrl.sv
// Controller model: sends 16-byte request telegrams and gathers answers.
// Assumes the bench calls xfer just after a rising clock edge.
`timescale 1ns/10ps

module mfr_ctrl (
	input  wire logic       clk,
	output logic            req_valid,
	input  wire logic       req_ready,
	output logic      [7:0] req_data,
	input  wire logic       rsp_valid,
	output logic            rsp_ready,
	input  wire logic [7:0] rsp_data
);
	logic stall_en;
	logic early;
	// Idle lines
	initial begin
		req_valid = 1'b0;
		req_data  = 8'hFF;
		rsp_ready = 1'b0;
		stall_en  = 1'b0;
		early     = 1'b0;
	end
	// One whole request, then the whole answer
	task automatic xfer(input logic [127:0] tel, output logic [127:0] rsp);
		int i;
		early = 1'b0;
		for (i = 0; i < 16; i++) begin
			req_valid = 1'b1;
			req_data  = tel[127-8*i -: 8];
			while (req_ready !== 1'b1) begin
				@(posedge clk);
				#1;
			end
			if (rsp_valid === 1'b1) begin
				early = 1'b1;
			end
			@(posedge clk);
			#1;
		end
		req_valid = 1'b0;
		req_data  = ~req_data; // Released line drops its old value
		for (i = 0; i < 16; i++) begin
			if (stall_en) begin
				rsp_ready = 1'b0;
				repeat (3) @(posedge clk);
				#1;
			end
			rsp_ready = 1'b1;
			while (rsp_valid !== 1'b1) begin
				@(posedge clk);
				#1;
			end
			rsp[127-8*i -: 8] = rsp_data;
			@(posedge clk);
			#1;
		end
		rsp_ready = 1'b0;
	endtask
endmodule

// ===== sim/tb.sv
// Bench for the telegram interpreter: read frame and command telegrams.
// Assumes the controller model in mfr_ctrl drives the request side.
`timescale 1ns/10ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end

module tb;
	import mfr_pkg::*;
	logic          clk;
	logic          reset_n;
	logic          req_valid;
	logic          req_ready;
	logic [7:0]    req_data;
	logic          rsp_valid;
	logic          rsp_ready;
	logic [7:0]    rsp_data;
	mfr_frame_type frame_cfg;
	mfr_meas_type  meas;
	logic [31:0]   holding_value;
	mfr_cmd_type   cmd;
	mfr_cmd_type   cmd_cap;
	int            pulse_len;
	int            failures;
	int            n_checks;
	int            cyc;

	mfr_telegram mfr_telegram_i (.clk(clk), .reset_n(reset_n), .req_valid(req_valid), .req_ready(req_ready),
		.req_data(req_data), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_data(rsp_data),
		.frame_cfg(frame_cfg), .meas(meas), .holding_value(holding_value), .cmd(cmd));
	mfr_ctrl mfr_ctrl_i (.clk(clk), .req_valid(req_valid), .req_ready(req_ready), .req_data(req_data),
		.rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_data(rsp_data));

	// Clock and hang guard
	always #20 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			give_verdict();
		end
	end
	// Catch command strobes and their length
	always @(posedge clk) begin
		if (cmd.reset_energy | cmd.reset_status | cmd.preset) begin
			cmd_cap   <= cmd;
			pulse_len <= pulse_len + 1;
		end
	end

	task automatic give_verdict();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic run(input logic [127:0] tel, input logic [127:0] ex);
		logic [127:0] got;
		pulse_len = 0;
		cmd_cap   = '0;
		mfr_ctrl_i.xfer(tel, got);
		`CHK(got, ex)
		`CHK(mfr_ctrl_i.early, 1'b0)
	endtask

	task automatic set_frame(input mfr_kind_type k0, k1, k2, k3);
		frame_cfg.frame_id = 8'h01;
		frame_cfg.kind[0]  = k0;
		frame_cfg.kind[1]  = k1;
		frame_cfg.kind[2]  = k2;
		frame_cfg.kind[3]  = k3;
	endtask

	// Frame reads: plain, stalled back to back, overrun skip, unknown frame
	task automatic t_read();
		set_frame(MK_ENERGY, MK_PF, MK_FREQ, MK_NONE);
		run({32'h25010100, 96'h0}, {32'h20017100, 32'h0007A120, 24'h5A1388, 40'h0});
		mfr_ctrl_i.stall_en = 1'b1;
		run({32'h20010300, 96'h0}, {32'h20017300, 32'h0007A120, 24'h5A1388, 40'h0});
		mfr_ctrl_i.stall_en = 1'b0;
		set_frame(MK_PF, MK_ENERGY, MK_ENERGY, MK_ENERGY);
		run({32'h20010200, 96'h0}, {32'h20019200, 8'h5A, 64'h0007A1200007A120, 24'h0});
		run({32'h20070100, 96'h0}, {32'h20070101, 96'h0});
	endtask

	// Every command, bad ones and an unknown type
	task automatic t_cmd();
		run({32'h40010000, 96'h0}, {32'h40010000, 96'h0});
		`CHK(cmd_cap.reset_energy, 1'b1)
		`CHK(pulse_len, 1)
		run({32'h40034000, 32'hDEADBEEF, 64'h0}, {32'h40030000, 96'h0});
		`CHK({cmd_cap.reset_status, cmd_cap.status_mask}, 33'h1DEADBEEF)
		`CHK(pulse_len, 1)
		run({32'h40040000, 96'h0}, {32'h40044000, FW_VERSION, 64'h0});
		holding_value = 32'h89ABCDEF;
		run({32'h40060000, 96'h0}, {32'h40064000, 32'h89ABCDEF, 64'h0});
		run({32'h40076000, 48'h050200001234, 48'h0}, {32'h40070000, 96'h0});
		`CHK({cmd_cap.preset, cmd_cap.preset_id, cmd_cap.preset_overflow}, 17'h10502)
		`CHK(cmd_cap.preset_value, 32'h00001234)
		`CHK(pulse_len, 1)
		run({32'h40076000, 48'h090200001234, 48'h0}, {32'h40070003, 96'h0});
		`CHK(pulse_len, 0)
		run({32'h40020000, 96'h0}, {32'h40020003, 96'h0});
		run({32'h30010000, 96'h0}, {32'h30010002, 96'h0});
	endtask

	initial begin
		clk           = 1'b0;
		reset_n       = 1'b0;
		frame_cfg     = '0;
		meas          = {32'h0007A120, 8'h5A, 16'h1388};
		holding_value = 32'h0;
		cmd_cap       = '0;
		pulse_len     = 0;
		failures      = 0;
		n_checks      = 0;
		cyc           = 0;
		repeat (3) @(posedge clk);
		#1;
		reset_n = 1'b1;
		`CHK({req_ready, rsp_valid}, 2'b10)
		t_read();
		t_cmd();
		give_verdict();
	end
endmodule

// ===== verilog/mfr_pkg.sv
// Package for the frame-read telegram interpreter: layout, codes, types.
// Assumes a byte-wide request and response stream at the module boundary.
package mfr_pkg;
	// Telegram layout
	localparam int HDR_BYTES  = 4;
	localparam int DATA_BYTES = 12;
	localparam int TEL_BYTES  = 16;
	localparam logic [3:0] LAST_BYTE = 4'hF;
	localparam int B_CTRL = 0;
	localparam int B_IDENT = 1;
	localparam int B_LEN = 2;
	localparam int B_STAT = 3;
	// Telegram type codes in bits 6..4 of byte 0
	localparam logic [2:0] TYPE_READ_FRAME = 3'h2;
	localparam logic [2:0] TYPE_COMMAND    = 3'h4;
	// Measurand sizes in bytes
	localparam int SZ_ENERGY = 4;
	localparam int SZ_PF     = 1;
	localparam int SZ_FREQ   = 2;
	localparam int SZ_WORD   = 4;
	localparam int FRAME_SLOTS = 4;
	// Command identifiers
	localparam logic [7:0] CMD_RESET_ENERGY = 8'h01;
	localparam logic [7:0] CMD_RESET_STATUS = 8'h03;
	localparam logic [7:0] CMD_FW_VERSION   = 8'h04;
	localparam logic [7:0] CMD_READ_HOLDING = 8'h06;
	localparam logic [7:0] CMD_PRESET_METER = 8'h07;
	localparam logic [7:0] PRESET_ID_MIN    = 8'h03;
	localparam logic [7:0] PRESET_ID_MAX    = 8'h08;
	// Status codes
	localparam logic [3:0] COMM_OK       = 4'h0;
	localparam logic [7:0] CS_OK         = 8'h00;
	localparam logic [7:0] CS_NO_FRAME   = 8'h01;
	localparam logic [7:0] CS_BAD_TYPE   = 8'h02;
	localparam logic [7:0] CS_BAD_CMD    = 8'h03;
	// Firmware version, arbitrary value
	localparam logic [31:0] FW_VERSION = 32'h0001_0000;
	localparam int FIFO_DEPTH = 8;

	typedef enum logic [1:0] {
		MK_NONE   = 2'b00,
		MK_ENERGY = 2'b01,
		MK_PF     = 2'b10,
		MK_FREQ   = 2'b11
	} mfr_kind_type;

	typedef enum logic [1:0] {
		ST_RX    = 2'b00,
		ST_BUILD = 2'b01,
		ST_SEND  = 2'b10
	} mfr_state_type;

	typedef struct packed {
		logic [7:0]                        frame_id;
		mfr_kind_type [FRAME_SLOTS-1:0]    kind;
	} mfr_frame_type;

	typedef struct packed {
		logic [31:0] energy;
		logic [7:0]  power_factor;
		logic [15:0] frequency;
	} mfr_meas_type;

	typedef struct packed {
		logic        reset_energy;
		logic        reset_status;
		logic [31:0] status_mask;
		logic        preset;
		logic [7:0]  preset_id;
		logic [7:0]  preset_overflow;
		logic [31:0] preset_value;
	} mfr_cmd_type;
endpackage

// ===== verilog/mfr_telegram.sv
// Frame-read and command telegram interpreter with its response FIFO.
// Assumes requests arrive as 16-byte blocks, byte 0 first, on a
// valid/ready stream, and measurands arrive already in the set format.
//
// Operation
// [R1] The requester sends 0x20 in byte 0 for a frame read, type 010 in bits 6..4.
// [R2] The low nibble of request byte 0 is ignored by the module.
// [R3] The response repeats the type in bits 6..4 of byte 0 with comm status in bits 3..0.
// [R4] The requester puts the wanted frame identifier in request byte 1.
// [R5] The response carries the request's frame identifier unchanged in byte 1.
// [R6] The requester sets the length nibble of request byte 2 to zero.
// [R7] The requester puts the data set identifier in bits 3..0 of request byte 2.
// [R8] The response gives the count of user-data bytes in bits 7..4 of byte 2.
// [R9] The response echoes the data set identifier in bits 3..0 of byte 2.
// [R10] Response byte 3 is the overall status, zero on success.
// [R11] User bytes D00..D11 carry the frame's measured values in the set format.
// [R12] Measurands are packed back to back: energy 4, power factor 1, frequency 2 bytes.
// [R13] Command telegrams reset energy, reset status, read version, read holding, preset meters.
// [R14] Energy values written by a command are always integers.
// [R15] Command telegrams use type 100, first byte 0x40, both ways.
// [R16] Telegrams are 4 header plus 12 data bytes; the answer follows the full request.
`timescale 1ns/10ps

module mfr_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW:0]      wr_r;
	logic [AW:0]      wr_nxt;
	logic [AW:0]      rd_r;
	logic [AW:0]      rd_nxt;
	logic             push;
	logic             pop;

	// Full and empty from the wrap bit
	assign in_ready  = !((wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]));
	assign out_valid = (wr_r != rd_r);
	assign out_data  = mem_r[rd_r[AW-1:0]];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Pointer advance
	always_comb begin
		wr_nxt = push ? wr_r + 1'b1 : wr_r;
		rd_nxt = pop ? rd_r + 1'b1 : rd_r;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_r <= '0;
			rd_r <= '0;
		end else begin
			wr_r <= wr_nxt;
			rd_r <= rd_nxt;
		end
	end

	// Storage, no reset needed
	always_ff @(posedge clk) begin
		if (push) begin
			mem_r[wr_r[AW-1:0]] <= in_data;
		end
	end
endmodule

module mfr_telegram (
	input  wire logic                   clk,
	input  wire logic                   reset_n,
	input  wire logic                   req_valid,
	output logic                        req_ready,
	input  wire logic [7:0]             req_data,
	output logic                        rsp_valid,
	input  wire logic                   rsp_ready,
	output logic      [7:0]             rsp_data,
	input  wire mfr_pkg::mfr_frame_type frame_cfg,
	input  wire mfr_pkg::mfr_meas_type  meas,
	input  wire logic [31:0]            holding_value,
	output mfr_pkg::mfr_cmd_type        cmd
);
	import mfr_pkg::*;

	mfr_state_type            state_r;
	mfr_state_type            state_nxt;
	logic [3:0]               cnt_r;
	logic [3:0]               cnt_nxt;
	logic [TEL_BYTES-1:0][7:0] req_r;
	logic [TEL_BYTES-1:0][7:0] req_nxt;
	logic [TEL_BYTES-1:0][7:0] rsp_r;
	logic [TEL_BYTES-1:0][7:0] rsp_nxt;
	logic [TEL_BYTES-1:0][7:0] rsp_b;
	mfr_cmd_type              cmd_r;
	mfr_cmd_type              cmd_nxt;
	mfr_cmd_type              cmd_b;
	logic                     fifo_valid;
	logic                     fifo_ready;
	logic                     rx_take;
	logic                     tx_take;
	logic [2:0]               typ;
	logic [3:0]               len;
	logic [7:0]               stat;
	int                       pos;

	assign req_ready  = (state_r == ST_RX);
	assign fifo_valid = (state_r == ST_SEND);
	assign rx_take    = req_valid && req_ready;
	assign tx_take    = fifo_valid && fifo_ready;
	assign cmd        = cmd_r;
	assign typ        = req_r[B_CTRL][6:4]; // R2

	// Response and command decode from the stored request
	always_comb begin
		rsp_b = '0;
		cmd_b = '0;
		pos   = HDR_BYTES;
		stat  = CS_OK;
		if (typ == TYPE_READ_FRAME) begin
			if (req_r[B_IDENT] != frame_cfg.frame_id) begin
				stat = CS_NO_FRAME; // R10
			end else begin
				// Pack measurands back to back, dropping any that overrun
				for (int i = 0; i < FRAME_SLOTS; i++) begin
					case (frame_cfg.kind[i])
					MK_ENERGY: begin
						if (pos + SZ_ENERGY <= TEL_BYTES) begin
							for (int k = 0; k < SZ_ENERGY; k++) begin
								rsp_b[pos+k] = meas.energy[8*(SZ_ENERGY-1-k) +: 8]; // R12 R11
							end
							pos = pos + SZ_ENERGY;
						end
					end
					MK_PF: begin
						if (pos + SZ_PF <= TEL_BYTES) begin
							rsp_b[pos] = meas.power_factor; // R12
							pos = pos + SZ_PF;
						end
					end
					MK_FREQ: begin
						if (pos + SZ_FREQ <= TEL_BYTES) begin
							for (int k = 0; k < SZ_FREQ; k++) begin
								rsp_b[pos+k] = meas.frequency[8*(SZ_FREQ-1-k) +: 8]; // R12
							end
							pos = pos + SZ_FREQ;
						end
					end
					default: begin
					end
					endcase
				end
			end
		end else if (typ == TYPE_COMMAND) begin
			case (req_r[B_IDENT]) // R13
			CMD_RESET_ENERGY: begin
				cmd_b.reset_energy = 1'b1;
			end
			CMD_RESET_STATUS: begin
				cmd_b.reset_status = 1'b1;
				cmd_b.status_mask  = {req_r[HDR_BYTES], req_r[HDR_BYTES+1], req_r[HDR_BYTES+2], req_r[HDR_BYTES+3]};
			end
			CMD_FW_VERSION: begin
				for (int k = 0; k < SZ_WORD; k++) begin
					rsp_b[HDR_BYTES+k] = FW_VERSION[8*(SZ_WORD-1-k) +: 8];
				end
				pos = HDR_BYTES + SZ_WORD;
			end
			CMD_READ_HOLDING: begin
				for (int k = 0; k < SZ_WORD; k++) begin
					rsp_b[HDR_BYTES+k] = holding_value[8*(SZ_WORD-1-k) +: 8];
				end
				pos = HDR_BYTES + SZ_WORD;
			end
			CMD_PRESET_METER: begin
				// Preset value is taken as a plain integer
				if (req_r[HDR_BYTES] >= PRESET_ID_MIN && req_r[HDR_BYTES] <= PRESET_ID_MAX) begin
					cmd_b.preset          = 1'b1;
					cmd_b.preset_id       = req_r[HDR_BYTES];
					cmd_b.preset_overflow = req_r[HDR_BYTES+1];
					cmd_b.preset_value    = {req_r[HDR_BYTES+2], req_r[HDR_BYTES+3],
						req_r[HDR_BYTES+4], req_r[HDR_BYTES+5]}; // R14
				end else begin
					stat = CS_BAD_CMD;
				end
			end
			default: begin
				stat = CS_BAD_CMD;
			end
			endcase
		end else begin
			stat = CS_BAD_TYPE;
		end
		len             = 4'(pos - HDR_BYTES);
		rsp_b[B_CTRL]   = {1'b0, typ, COMM_OK}; // R3 R15
		rsp_b[B_IDENT]  = req_r[B_IDENT]; // R5
		rsp_b[B_LEN]    = {len, req_r[B_LEN][3:0]}; // R8 R9
		rsp_b[B_STAT]   = stat; // R10
	end

	// Sequencer: receive 16 bytes, build once, send 16 bytes
	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		req_nxt   = req_r;
		rsp_nxt   = rsp_r;
		cmd_nxt   = '0;
		case (state_r)
		ST_RX: begin
			if (rx_take) begin
				req_nxt[cnt_r] = req_data;
				cnt_nxt        = cnt_r + 1'b1;
				if (cnt_r == LAST_BYTE) begin
					state_nxt = ST_BUILD; // R16
				end
			end
		end
		ST_BUILD: begin
			rsp_nxt   = rsp_b;
			cmd_nxt   = cmd_b;
			cnt_nxt   = '0;
			state_nxt = ST_SEND;
		end
		ST_SEND: begin
			if (tx_take) begin
				cnt_nxt = cnt_r + 1'b1;
				if (cnt_r == LAST_BYTE) begin
					state_nxt = ST_RX;
				end
			end
		end
		default: begin
			state_nxt = ST_RX;
			cnt_nxt   = '0;
		end
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= ST_RX;
			cnt_r   <= '0;
			req_r   <= '0;
			rsp_r   <= '0;
			cmd_r   <= '0;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			req_r   <= req_nxt;
			rsp_r   <= rsp_nxt;
			cmd_r   <= cmd_nxt;
		end
	end

	// Response bytes queue toward the requester
	mfr_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.reset_n   (reset_n),
		.in_valid  (fifo_valid),
		.in_ready  (fifo_ready),
		.in_data   (rsp_r[cnt_r]),
		.out_valid (rsp_valid),
		.out_ready (rsp_ready),
		.out_data  (rsp_data)
	);

	// Checks on the response built, the sequencer and the energy reset strobe
	AST_TYPE_ECHO: assert property (@(posedge clk) disable iff (!reset_n) // R3
		(state_r == ST_SEND && typ == TYPE_READ_FRAME) |-> rsp_r[B_CTRL] == 8'h20)
		else $error("read frame response byte 0 wrong");
	AST_CMD_TYPE: assert property (@(posedge clk) disable iff (!reset_n) // R15
		(state_r == ST_SEND && typ == TYPE_COMMAND) |-> rsp_r[B_CTRL] == 8'h40)
		else $error("command response byte 0 wrong");
	AST_FRAME_ID: assert property (@(posedge clk) disable iff (!reset_n) // R5
		(state_r == ST_SEND) |-> rsp_r[B_IDENT] == req_r[B_IDENT])
		else $error("frame identifier not echoed");
	AST_DATA_SET_IDENTIFIER: assert property (@(posedge clk) disable iff (!reset_n) // R9
		(state_r == ST_SEND) |-> rsp_r[B_LEN][3:0] == req_r[B_LEN][3:0])
		else $error("data set identifier not echoed");
	AST_LEN_MAX: assert property (@(posedge clk) disable iff (!reset_n) // R8
		(state_r == ST_SEND) |-> rsp_r[B_LEN][7:4] <= 4'(DATA_BYTES))
		else $error("user data length above 12");
	AST_STATUS: assert property (@(posedge clk) disable iff (!reset_n) // R10
		(state_r == ST_BUILD && typ == TYPE_READ_FRAME && req_r[B_IDENT] == frame_cfg.frame_id)
		|=> rsp_r[B_STAT] == 8'h00)
		else $error("status not zero on good read");
	AST_FULL_REQ: assert property (@(posedge clk) disable iff (!reset_n) // R16
		(rx_take && cnt_r == LAST_BYTE) |=> state_r == ST_BUILD ##1 state_r == ST_SEND && !req_ready)
		else $error("answer not started after full request");
	AST_RST_PULSE: assert property (@(posedge clk) disable iff (!reset_n) // R13
		cmd_r.reset_energy |-> $past(state_r) == ST_BUILD && req_r[B_IDENT] == CMD_RESET_ENERGY
		##1 !cmd_r.reset_energy)
		else $error("energy reset pulse without command");
	AST_ENERGY_POS: assert property (@(posedge clk) disable iff (!reset_n) // R12
		(state_r == ST_BUILD && typ == TYPE_READ_FRAME && req_r[B_IDENT] == frame_cfg.frame_id
		&& frame_cfg.kind[0] == MK_ENERGY) |=> rsp_r[HDR_BYTES] == $past(meas.energy[31:24]))
		else $error("energy not first in frame");
endmodule
